// ---- hw/plbw_ctrl.sv ----
// Loop bandwidth mode control with lock flag, interrupt and divider fields
//
// Operation
// - fine_loop_select clear means acquisition mode, large VCO corrections.
// - Tracking mode whenever not acquiring or fine_loop_select set.
// - With automatic mode on, lock detector switches filter mode itself.
// - In automatic mode fine_loop_select is read-only, shows filter mode.
// - Automatic mode: fine_loop_select follows acquisition tolerance detector.
// - Automatic mode: freq_settled_flag follows lock tolerance, read-only.
// - Automatic mode with interrupt enabled: each lock toggle raises interrupt.
// - Manual mode: fine_loop_select is writable and sets filter mode.
// - Manual mode disables lock indicator and all loop interrupts.
// - Prescaler exponent is 0 to 3; VCO clock scales by its power.
// - Multiplier N is 12 bits, 1 to 4095, over two registers.
// - P, E, N, L and R writes accepted only while loop is off.
// - Flag sets on lock toggle, clears on control read, zero in manual.
// - In manual mode the interrupt enable ignores writes, reads zero.
// - Zero for R or N acts exactly as one.
// - No base select while off; no power off while base selected; a single write setting select and clearing power while on still does both.
//
// Design decisions made here: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module plbw_ctrl (
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        reset_n,
  // AXI4-Lite write address and data
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // AXI4-Lite read
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Lock detector levels from the analog loop
  input  wire logic        acq_tol_in,
  input  wire logic        lock_tol_in,
  // Loop controls toward the analog loop and clock selector
  output logic             filter_track,
  output logic             loop_power_on,
  output logic             base_source_select,
  output logic [1:0]       vco_divider_exp,
  output logic [1:0]       vco_range_exp,
  output logic [11:0]      mult_eff,
  output logic [7:0]       vco_center,
  output logic [3:0]       ref_div_eff,
  // Status
  output logic             freq_settled_flag,
  output logic             loop_irq
);
  // ---------------------------------------------------------------
  // Detector synchronisation
  // ---------------------------------------------------------------
  logic [1:0] det_s;
  plbw_sync #(.WIDTH(2)) u_sync (
    .mclk     (mclk),
    .reset_n  (reset_n),
    .async_in ({lock_tol_in, acq_tol_in}),
    .sync_out (det_s)
  );

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  logic        auto_r,    auto_nxt;
  logic        acq_r,     acq_nxt;
  logic        irq_en_r,  irq_en_nxt;
  logic        flag_r,    flag_nxt;
  logic        lock_q_r,  lock_q_nxt;
  logic        pon_r,     pon_nxt;
  logic        bsel_r,    bsel_nxt;
  logic [1:0]  pre_r,     pre_nxt;
  logic [1:0]  vpr_r,     vpr_nxt;
  logic [11:0] mult_r,    mult_nxt;
  logic [7:0]  center_r,  center_nxt;
  logic [3:0]  ref_r,     ref_nxt;
  logic [11:0] meff_r,    meff_nxt;
  logic [3:0]  reff_r,    reff_nxt;
  logic        awh_r,     awh_nxt;
  logic [7:0]  awa_r,     awa_nxt;
  logic        wh_r,      wh_nxt;
  logic [7:0]  wd_r,      wd_nxt;
  logic        ws_r,      ws_nxt;
  logic        bvalid_r,  bvalid_nxt;
  logic [1:0]  bresp_r,   bresp_nxt;
  logic        rvalid_r,  rvalid_nxt;
  logic [1:0]  rresp_r,   rresp_nxt;
  logic [7:0]  rdata_r,   rdata_nxt;

  logic        acq_s;
  logic        lock_s;
  logic        lock_st;
  logic        acq_rd;
  logic        aw_have;
  logic        w_have;
  logic        wr_fire;
  logic        rd_fire;
  logic [5:0]  wr_idx;
  logic [7:0]  wr_byte;
  logic        wr_en;
  logic [5:0]  rd_idx;
  logic        toggle;
  logic        ctrl_wr;
  logic        bwc_wr;
  logic        mull_wr;
  logic        ctrl_rd;

  assign acq_s  = det_s[0];
  assign lock_s = det_s[1];

  // ---------------------------------------------------------------
  // Mode and status views
  // ---------------------------------------------------------------
  // Lock indicator is disabled outside automatic mode
  assign lock_st = auto_r & lock_s;
  // Detector drives the filter in automatic mode, software otherwise
  assign acq_rd  = auto_r ? acq_s : acq_r;
  // Clear selects acquisition, set selects tracking
  assign filter_track = acq_rd;
  assign toggle  = auto_r & (lock_s != lock_q_r);

  // ---------------------------------------------------------------
  // Bus handshakes
  // ---------------------------------------------------------------
  assign s_axi_awready = !awh_r && !bvalid_r;
  assign s_axi_wready  = !wh_r && !bvalid_r;
  assign s_axi_arready = !rvalid_r;
  assign aw_have = awh_r | (s_axi_awvalid & s_axi_awready);
  assign w_have  = wh_r | (s_axi_wvalid & s_axi_wready);
  assign wr_fire = aw_have & w_have & !bvalid_r;
  assign rd_fire = s_axi_arvalid & s_axi_arready;
  assign wr_idx  = awh_r ? awa_r[7:2] : s_axi_awaddr[7:2];
  assign wr_byte = wh_r ? wd_r : s_axi_wdata[7:0];
  assign wr_en   = wr_fire & (wh_r ? ws_r : s_axi_wstrb[0]);
  assign rd_idx  = s_axi_araddr[7:2];
  assign ctrl_wr = wr_en && (wr_idx == plbw_pkg::IDX_CTRL);
  assign bwc_wr  = wr_en && (wr_idx == plbw_pkg::IDX_BWC);
  assign mull_wr = wr_en && (wr_idx == plbw_pkg::IDX_MULL);
  assign ctrl_rd = rd_fire && (rd_idx == plbw_pkg::IDX_CTRL);

  // Decode hit for either direction
  function automatic logic hit(input logic [5:0] idx);
    hit = (idx >= plbw_pkg::IDX_CTRL) && (idx <= plbw_pkg::IDX_REFDIV);
  endfunction

  // ---------------------------------------------------------------
  // Bus channel next state
  // ---------------------------------------------------------------
  always_comb begin
    awh_nxt    = awh_r;
    awa_nxt    = awa_r;
    wh_nxt     = wh_r;
    wd_nxt     = wd_r;
    ws_nxt     = ws_r;
    bvalid_nxt = bvalid_r;
    bresp_nxt  = bresp_r;
    rvalid_nxt = rvalid_r;
    rresp_nxt  = rresp_r;
    rdata_nxt  = rdata_r;
    if (wr_fire) begin
      awh_nxt    = 1'b0;
      wh_nxt     = 1'b0;
      bvalid_nxt = 1'b1;
      bresp_nxt  = hit(wr_idx) ? plbw_pkg::RESP_OKAY : plbw_pkg::RESP_SLVERR;
    end else begin
      // Park whichever half arrived first
      if (s_axi_awvalid && s_axi_awready) begin
        awh_nxt = 1'b1;
        awa_nxt = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wh_nxt = 1'b1;
        wd_nxt = s_axi_wdata[7:0];
        ws_nxt = s_axi_wstrb[0];
      end
    end
    if (bvalid_r && s_axi_bready) begin
      bvalid_nxt = 1'b0;
    end
    if (rd_fire) begin
      rvalid_nxt = 1'b1;
      rresp_nxt  = hit(rd_idx) ? plbw_pkg::RESP_OKAY : plbw_pkg::RESP_SLVERR;
      unique case (rd_idx)
        plbw_pkg::IDX_CTRL:   rdata_nxt = {irq_en_r, flag_r, pon_r, bsel_r,
                                           pre_r, vpr_r};
        plbw_pkg::IDX_BWC:    rdata_nxt = {auto_r, lock_st, acq_rd, 5'h00};
        plbw_pkg::IDX_MULH:   rdata_nxt = {4'h0, mult_r[11:8]};
        plbw_pkg::IDX_MULL:   rdata_nxt = mult_r[7:0];
        plbw_pkg::IDX_CENTER: rdata_nxt = center_r;
        plbw_pkg::IDX_REFDIV: rdata_nxt = {4'h0, ref_r};
        default:              rdata_nxt = 8'h00;
      endcase
    end else if (rvalid_r && s_axi_rready) begin
      rvalid_nxt = 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Control register next state
  // ---------------------------------------------------------------
  always_comb begin
    auto_nxt   = auto_r;
    acq_nxt    = acq_r;
    irq_en_nxt = irq_en_r;
    pon_nxt    = pon_r;
    bsel_nxt   = bsel_r;
    pre_nxt    = pre_r;
    vpr_nxt    = vpr_r;
    mult_nxt   = mult_r;
    center_nxt = center_r;
    ref_nxt    = ref_r;
    lock_q_nxt = lock_s;
    if (ctrl_wr) begin
      irq_en_nxt = wr_byte[plbw_pkg::CTRL_IRQ_EN] & auto_r;
      // Power stays on while the loop clock drives the base clock
      pon_nxt = bsel_r | wr_byte[plbw_pkg::CTRL_PON];
      // Selecting needs the loop already on and a nonzero center
      bsel_nxt = wr_byte[plbw_pkg::CTRL_BSEL] & pon_r &
                 (center_r != 8'h00);
      if (!pon_r) begin
        pre_nxt = wr_byte[plbw_pkg::CTRL_PRE_LO +: 2];
        vpr_nxt = wr_byte[plbw_pkg::CTRL_VPR_LO +: 2];
      end
    end
    if (bwc_wr) begin
      auto_nxt = wr_byte[plbw_pkg::BWC_AUTO];
      if (!auto_r) begin
        acq_nxt = wr_byte[plbw_pkg::BWC_ACQ];
      end
    end
    if (wr_en && !pon_r) begin
      unique case (wr_idx)
        plbw_pkg::IDX_MULH:   mult_nxt[11:8] = wr_byte[3:0];
        plbw_pkg::IDX_MULL:   mult_nxt[7:0]  = wr_byte;
        plbw_pkg::IDX_CENTER: center_nxt     = wr_byte;
        plbw_pkg::IDX_REFDIV: ref_nxt        = wr_byte[3:0];
        default:              ;
      endcase
    end
    // Leaving automatic mode forces the enable clear
    if (!auto_nxt) begin
      irq_en_nxt = 1'b0;
    end
  end

  // Flag: a toggle in the same cycle as the clearing read wins
  always_comb begin
    flag_nxt = toggle | (flag_r & !ctrl_rd);
    // Judged on the next mode, so leaving auto never leaves a stale flag
    if (!auto_nxt) begin
      flag_nxt = 1'b0;
    end
  end

  // Zero multipliers and dividers behave as one
  assign meff_nxt = (mult_nxt == 12'h000) ? 12'h001 : mult_nxt;
  assign reff_nxt = (ref_nxt == 4'h0) ? 4'h1 : ref_nxt;

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      auto_r   <= 1'b0;
      acq_r    <= 1'b0;
      irq_en_r <= 1'b0;
      flag_r   <= 1'b0;
      lock_q_r <= 1'b0;
      pon_r    <= plbw_pkg::RST_PON;
      bsel_r   <= 1'b0;
      pre_r    <= 2'h0;
      vpr_r    <= 2'h0;
      mult_r   <= plbw_pkg::RST_MULT;
      center_r <= plbw_pkg::RST_CENTER;
      ref_r    <= plbw_pkg::RST_REFDIV;
      meff_r   <= plbw_pkg::RST_MULT;
      reff_r   <= plbw_pkg::RST_REFDIV;
      awh_r    <= 1'b0;
      awa_r    <= 8'h00;
      wh_r     <= 1'b0;
      wd_r     <= 8'h00;
      ws_r     <= 1'b0;
      bvalid_r <= 1'b0;
      bresp_r  <= 2'h0;
      rvalid_r <= 1'b0;
      rresp_r  <= 2'h0;
      rdata_r  <= 8'h00;
    end else begin
      auto_r   <= auto_nxt;
      acq_r    <= acq_nxt;
      irq_en_r <= irq_en_nxt;
      flag_r   <= flag_nxt;
      lock_q_r <= lock_q_nxt;
      pon_r    <= pon_nxt;
      bsel_r   <= bsel_nxt;
      pre_r    <= pre_nxt;
      vpr_r    <= vpr_nxt;
      mult_r   <= mult_nxt;
      center_r <= center_nxt;
      ref_r    <= ref_nxt;
      meff_r   <= meff_nxt;
      reff_r   <= reff_nxt;
      awh_r    <= awh_nxt;
      awa_r    <= awa_nxt;
      wh_r     <= wh_nxt;
      wd_r     <= wd_nxt;
      ws_r     <= ws_nxt;
      bvalid_r <= bvalid_nxt;
      bresp_r  <= bresp_nxt;
      rvalid_r <= rvalid_nxt;
      rresp_r  <= rresp_nxt;
      rdata_r  <= rdata_nxt;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign s_axi_bvalid       = bvalid_r;
  assign s_axi_bresp        = bresp_r;
  assign s_axi_rvalid       = rvalid_r;
  assign s_axi_rresp        = rresp_r;
  assign s_axi_rdata        = {24'h000000, rdata_r};
  assign loop_power_on      = pon_r;
  assign base_source_select = bsel_r;
  assign vco_divider_exp    = pre_r;
  assign vco_range_exp      = vpr_r;
  assign mult_eff           = meff_r;
  assign vco_center         = center_r;
  assign ref_div_eff        = reff_r;
  assign freq_settled_flag  = lock_st;
  // Interrupt only in automatic mode with the enable set
  assign loop_irq = flag_r & irq_en_r & auto_r;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);

  sequence s_acq_rise;
    (auto_r && $rose(acq_tol_in)) ##1 (auto_r && acq_tol_in) [*2];
  endsequence
  sequence s_lock_rise;
    (auto_r && $rose(lock_tol_in)) ##1 (auto_r && lock_tol_in) [*2];
  endsequence

  property p_manual_mode_write;
    (bwc_wr && !auto_r && wr_byte[plbw_pkg::BWC_ACQ]
     && wr_byte[plbw_pkg::BWC_AUTO] == 1'b0) |=> filter_track;
  endproperty
  a_manual_mode_write: assert property (p_manual_mode_write)
    else $error("manual filter mode write not applied");

  property p_auto_follows_acq;
    s_acq_rise |-> filter_track;
  endproperty
  a_auto_follows_acq: assert property (p_auto_follows_acq)
    else $error("filter mode did not follow detector");

  property p_auto_ignores_write;
    (bwc_wr && auto_r) |=> $stable(acq_r);
  endproperty
  a_auto_ignores_write: assert property (p_auto_ignores_write)
    else $error("filter mode bit written in automatic mode");

  property p_lock_follows;
    s_lock_rise |-> freq_settled_flag;
  endproperty
  a_lock_follows: assert property (p_lock_follows)
    else $error("settled flag did not follow lock detector");

  property p_toggle_irq;
    (toggle && irq_en_r && auto_nxt && irq_en_nxt) |=> loop_irq;
  endproperty
  a_toggle_irq: assert property (p_toggle_irq)
    else $error("lock toggle raised no interrupt");

  property p_manual_quiet;
    !auto_r |-> (!loop_irq && !freq_settled_flag && !flag_r);
  endproperty
  a_manual_quiet: assert property (p_manual_quiet)
    else $error("indicator or interrupt active in manual mode");

  property p_read_clears;
    (ctrl_rd && !toggle) |=> !flag_r;
  endproperty
  a_read_clears: assert property (p_read_clears)
    else $error("control read did not clear flag");

  property p_irq_en_manual;
    !auto_r |-> !irq_en_r;
  endproperty
  a_irq_en_manual: assert property (p_irq_en_manual)
    else $error("interrupt enable set in manual mode");

  property p_locked_fields;
    (mull_wr && pon_r) |=> ($stable(mult_r) && $stable(meff_r));
  endproperty
  a_locked_fields: assert property (p_locked_fields)
    else $error("multiplier changed while loop on");

  property p_zero_as_one;
    (ref_div_eff != 4'h0) && (mult_eff != 12'h000);
  endproperty
  a_zero_as_one: assert property (p_zero_as_one)
    else $error("zero divider reached the loop");

  property p_select_guard;
    (!pon_r && !bsel_r) |=> !bsel_r;
  endproperty
  a_select_guard: assert property (p_select_guard)
    else $error("base select set with loop off");

  property p_power_hold;
    bsel_r |=> pon_r;
  endproperty
  a_power_hold: assert property (p_power_hold)
    else $error("loop turned off while selected");
endmodule

// ---- hw/plbw_pkg.sv ----
// Package: register map, field layout and reset values of the loop control
package plbw_pkg;
  // ---------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ---------------------------------------------------------------
  localparam logic [5:0] IDX_CTRL   = 6'h36; // loop_control_reg
  localparam logic [5:0] IDX_BWC    = 6'h37; // bandwidth control
  localparam logic [5:0] IDX_MULH   = 6'h38; // mult_high_reg
  localparam logic [5:0] IDX_MULL   = 6'h39; // mult_low_reg
  localparam logic [5:0] IDX_CENTER = 6'h3a; // vco_center_reg
  localparam logic [5:0] IDX_REFDIV = 6'h3b; // ref_divider_reg

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int CTRL_IRQ_EN  = 7;
  localparam int CTRL_IRQ_FLG = 6;
  localparam int CTRL_PON     = 5;
  localparam int CTRL_BSEL    = 4;
  localparam int CTRL_PRE_LO  = 2;
  localparam int CTRL_VPR_LO  = 0;
  localparam int BWC_AUTO     = 7;
  localparam int BWC_LOCK     = 6;
  localparam int BWC_ACQ      = 5;

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic        RST_PON    = 1'b1;
  localparam logic [11:0] RST_MULT   = 12'h040;
  localparam logic [7:0]  RST_CENTER = 8'h40;
  localparam logic [3:0]  RST_REFDIV = 4'h1;

  // Bus answers
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage

// ---- hw/plbw_sync.sv ----
// Two-flop synchroniser for a group of asynchronous level inputs
`timescale 1ns/1ps
module plbw_sync #(
  parameter int WIDTH = 2
) (
  // Clock and reset
  input  wire logic             mclk,
  input  wire logic             reset_n,
  // Levels
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  // ---------------------------------------------------------------
  // One pair of flops per bit; the first flop feeds only the second
  // ---------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < WIDTH; gi++) begin : g_bit
      logic stage1_r;
      logic stage2_r;
      always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
          stage1_r <= 1'b0;
          stage2_r <= 1'b0;
        end else begin
          stage1_r <= async_in[gi];
          stage2_r <= stage1_r;
        end
      end
      assign sync_out[gi] = stage2_r;
    end
  endgenerate
endmodule

// ---- verif/plbw_ctrl_tb.sv ----
// Self-checking testbench of the loop bandwidth mode control block
`timescale 1ns/1ps
module plbw_ctrl_tb;
  // ---------------------------------------------------------------
  // Signals
  // ---------------------------------------------------------------
  logic        mclk, reset_n;
  logic [7:0]  awaddr, araddr;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, resp;
  logic        arvalid, arready, rvalid, rready;
  logic        acq_tol_in, lock_tol_in, filter_track, pon, bsel;
  logic [1:0]  div_exp, rng_exp;
  logic [11:0] mult_eff;
  logic [7:0]  center;
  logic [3:0]  ref_div;
  logic        settled, irq;
  int          failures, checks_done, cycles;
  logic [31:0] rd;

  plbw_ctrl dut (
    .mclk(mclk), .reset_n(reset_n),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .acq_tol_in(acq_tol_in), .lock_tol_in(lock_tol_in),
    .filter_track(filter_track), .loop_power_on(pon),
    .base_source_select(bsel), .vco_divider_exp(div_exp),
    .vco_range_exp(rng_exp), .mult_eff(mult_eff), .vco_center(center),
    .ref_div_eff(ref_div), .freq_settled_flag(settled), .loop_irq(irq)
  );

  // ---------------------------------------------------------------
  // Clock, reset and watchdog
  // ---------------------------------------------------------------
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  // Whole run needs well under a thousand cycles
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      final_report();
    end
  end

  // ---------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------
  task automatic final_report();
    $display("checks %0d mismatches %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Outputs are looked at just after an edge, once its updates landed
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  // Address and data offered together, each released when taken
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic aw_on;
    logic w_on;
    @(posedge mclk);
    awaddr  <= a;
    awvalid <= 1'b1;
    wdata   <= {24'h0, d};
    wstrb   <= 4'hf;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    aw_on = 1'b1;
    w_on  = 1'b1;
    forever begin
      @(posedge mclk);
      if (aw_on && awready) begin
        awvalid <= 1'b0;
        aw_on = 1'b0;
      end
      if (w_on && wready) begin
        wvalid <= 1'b0;
        w_on = 1'b0;
      end
      if (bvalid) begin
        resp = bresp;
        bready <= 1'b0;
        break;
      end
    end
  endtask

  task automatic rdr(input logic [7:0] a, output logic [31:0] d);
    logic ar_on;
    @(posedge mclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    ar_on = 1'b1;
    forever begin
      @(posedge mclk);
      if (ar_on && arready) begin
        arvalid <= 1'b0;
        ar_on = 1'b0;
      end
      if (rvalid) begin
        d = rdata;
        resp = rresp;
        rready <= 1'b0;
        break;
      end
    end
  endtask

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  // Reset state, then divider fields locked and unlocked by power
  task automatic t_fields();
    rdr(8'hd8, rd);
    chk("ctrl_rst", rd, 32'h20);
    wr(8'he4, 8'h12);
    rdr(8'he4, rd);
    chk("mull_lock", rd, 32'h40);
    tick(1);
    chk("mult_lock", {20'h0, mult_eff}, 32'h040);
    // Loop off, then zero multiplier and divider
    wr(8'hd8, 8'h00);
    wr(8'he4, 8'h00);
    wr(8'hec, 8'h00);
    tick(2);
    chk("mult_zero", {20'h0, mult_eff}, 32'h001);
    chk("ref_zero", {28'h0, ref_div}, 32'h1);
    // Band exponent 2, never 3, center to match
    wr(8'he0, 8'h0f);
    wr(8'he4, 8'hff);
    wr(8'hd8, 8'h0e);
    wr(8'he8, 8'h55);
    tick(2);
    chk("mult_max", {20'h0, mult_eff}, 32'hfff);
    chk("div_exp", {30'h0, div_exp}, 32'h3);
    chk("rng_exp", {30'h0, rng_exp}, 32'h2);
    chk("center", {24'h0, center}, 32'h55);
    $display("test fields done");
  endtask

  // Manual mode: software drives the filter, no lock or interrupt
  task automatic t_manual();
    wr(8'hd8, 8'h8e);
    rdr(8'hd8, rd);
    chk("ie_man", rd, 32'h0e);
    wr(8'hdc, 8'h20);
    tick(2);
    chk("trk_man", {31'h0, filter_track}, 32'h1);
    lock_tol_in <= 1'b1;
    tick(6);
    chk("set_man", {31'h0, settled}, 32'h0);
    chk("irq_man", {31'h0, irq}, 32'h0);
    rdr(8'hdc, rd);
    chk("bwc_man", rd, 32'h20);
    wr(8'hdc, 8'h00);
    tick(2);
    chk("acq_man", {31'h0, filter_track}, 32'h0);
    lock_tol_in <= 1'b0;
    tick(6);
    $display("test manual done");
  endtask

  // Automatic mode, the preferred one detector drives everything
  task automatic t_auto();
    wr(8'hdc, 8'h80);
    acq_tol_in <= 1'b1;
    tick(6);
    chk("trk_auto", {31'h0, filter_track}, 32'h1);
    rdr(8'hdc, rd);
    chk("bwc_auto", rd, 32'ha0);
    // Mode bit written high here must not stick for manual mode later
    wr(8'hdc, 8'ha0);
    tick(2);
    chk("acq_ro", {31'h0, filter_track}, 32'h1);
    acq_tol_in <= 1'b0;
    tick(6);
    chk("acq_auto", {31'h0, filter_track}, 32'h0);
    wr(8'hd8, 8'h8e);
    lock_tol_in <= 1'b1;
    tick(6);
    chk("set_on", {31'h0, settled}, 32'h1);
    chk("irq_on", {31'h0, irq}, 32'h1);
    rdr(8'hd8, rd);
    chk("flag_rd", rd, 32'hce);
    tick(2);
    chk("irq_clr", {31'h0, irq}, 32'h0);
    lock_tol_in <= 1'b0;
    tick(6);
    chk("set_off", {31'h0, settled}, 32'h0);
    chk("irq_off", {31'h0, irq}, 32'h1);
    wr(8'hdc, 8'h00);
    tick(2);
    chk("irq_man2", {31'h0, irq}, 32'h0);
    chk("acq_kept", {31'h0, filter_track}, 32'h0);
    rdr(8'hd8, rd);
    chk("ctrl_man", rd, 32'h0e);
    $display("test auto done");
  endtask

  // Base select interlock against power, fields locked while on
  task automatic t_base();
    // Power on in manual mode with the mode bit clear
    wr(8'hd8, 8'h3e);
    rdr(8'hd8, rd);
    chk("bs_refuse", rd, 32'h2e);
    // Acquisition wait, then tracking
    tick(8);
    wr(8'hdc, 8'h20);
    tick(2);
    chk("trk_on", {31'h0, filter_track}, 32'h1);
    // Lock wait before choosing the loop clock
    tick(8);
    wr(8'hd8, 8'h3e);
    tick(2);
    chk("bs_set", {31'h0, bsel}, 32'h1);
    wr(8'hd8, 8'h00);
    rdr(8'hd8, rd);
    chk("pon_keep", rd, 32'h2e);
    chk("pon_out", {31'h0, pon}, 32'h1);
    wr(8'he8, 8'h11);
    rdr(8'he8, rd);
    chk("ctr_lock", rd, 32'h55);
    $display("test base done");
  endtask

  // Unmapped address answers with an error and reads zero
  task automatic t_unmapped();
    wr(8'h00, 8'hff);
    chk("wr_err", {30'h0, resp}, {30'h0, plbw_pkg::RESP_SLVERR});
    rdr(8'h00, rd);
    chk("rd_zero", rd, 32'h0);
    chk("rd_err", {30'h0, resp}, {30'h0, plbw_pkg::RESP_SLVERR});
    $display("test unmapped done");
  endtask

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    reset_n     = 1'b0;
    awaddr      = '0;
    awvalid     = 1'b0;
    wdata       = '0;
    wstrb       = '0;
    wvalid      = 1'b0;
    bready      = 1'b0;
    araddr      = '0;
    arvalid     = 1'b0;
    rready      = 1'b0;
    acq_tol_in  = 1'b0;
    lock_tol_in = 1'b0;
    failures    = 0;
    checks_done = 0;
    cycles      = 0;
    repeat (3) @(posedge mclk);
    reset_n <= 1'b1;
    t_fields();
    t_manual();
    t_auto();
    t_base();
    t_unmapped();
    final_report();
  end
endmodule
